/* rtl/motor_pwm_output_stage.sv */
// Purpose: output stage of a motor pwm unit: duty, dead time, fault, override
// Assumes: time-base count and period pulse come from logic on CLK_I
// Notes:   pin level 1 means active; fault pin is synchronised here
//
// Added by the designer: the register addresses and the address-and-strobe port.

`timescale 1ns/1ps
`default_nettype none

// Operation
// - unit B dead-time clock is 1, 2, 4 or 8 cycles per count by prescale code
// - unit A dead-time clock uses its own prescale code with the same encoding
// - unit B 6-bit dead-time count sits in bits 13 to 8
// - unit A 6-bit dead-time count sits in bits 5 to 0
// - per generator, active-going edge takes unit B when its select is 1, else A
// - per generator, inactive-going edge takes unit B when its select is 1, else A
// - on fault, enabled outputs go to their programmed force values
// - fault mode 1 applies the fault override cycle by cycle
// - fault mode 0 latches the outputs at their force values
// - a pair obeys the fault only when its fault enable is set
// - select 1 gives pin to generator, 0 to manual bit; selects reset to 1
// - with select cleared the pin follows its manual level
// - three 16-bit duty values, read and write, resetting to zero
// - single-pair instance: pair 2 and 3 controls have no effect
// - unimplemented bits ignore writes and read zero
// - pair mode 0 is complementary with dead time, 1 is independent
// - overrides apply at the period boundary when sync is set, else next cycle
module motor_pwm_output_stage
	import pwm_out_pkg::*;
#(
	parameter bit SINGLE_PAIR = 1'b0
)(
	input  wire logic                CLK_I,
	input  wire logic                RESETN_I,
	input  wire logic [ADDR_W-1:0]   ADDR_I,
	input  wire logic [15:0]         WDATA_I,
	input  wire logic                WR_I,
	input  wire logic                RD_I,
	output logic      [15:0]         RDATA_O,
	input  wire logic [14:0]         TB_COUNT_I,
	input  wire logic                PERIOD_BOUNDARY_I,
	input  wire logic                FAULT_A_I,
	output logic      [PAIRS-1:0]    HIGH_SIDE_OUTPUT_O,
	output logic      [PAIRS-1:0]    LOW_SIDE_OUTPUT_O
);

	localparam logic [15:0] M_SEL  = SINGLE_PAIR ? MASK_DT_SEL_1 : MASK_DT_SEL;
	localparam logic [15:0] M_FLT  = SINGLE_PAIR ? MASK_FAULT_1 : MASK_FAULT;
	localparam logic [15:0] M_OVR  = SINGLE_PAIR ? MASK_OVR_1 : MASK_OVR;
	localparam logic [15:0] M_DUT2 = SINGLE_PAIR ? RST_ZERO : MASK_DUTY;
	localparam logic [15:0] M_AUX  = SINGLE_PAIR ? MASK_AUX_1 : MASK_AUX;
	localparam logic [15:0] R_OVR  = SINGLE_PAIR ? RST_OVR_1 : RST_OVR;

	logic [15:0] regs_ff [REG_COUNT];
	logic [15:0] nxt_regs [REG_COUNT];
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	logic [15:0] wmask;
	logic [2:0]  fault_sync_ff;
	logic        fault_lvl_ff;
	logic        nxt_fault_lvl;
	logic        fault_active_ff;
	logic        nxt_fault_active;
	logic        force_now;
	logic        fault_wr;
	logic [15:0] ovr_eff_ff;
	logic [15:0] nxt_ovr_eff;
	logic        ovr_take;
	pin_pair_s   pins_ff [PAIRS];
	pin_pair_s   nxt_pins [PAIRS];
	pin_pair_s   gen_pins [PAIRS];

	// writable bits of the addressed register
	always_comb
	begin
		unique case (ADDR_I)
			IDX_DT_CTRL:  wmask = MASK_DT_CTRL;
			IDX_DT_SEL:   wmask = M_SEL;
			IDX_FAULT:    wmask = M_FLT;
			IDX_OVERRIDE: wmask = M_OVR;
			IDX_DUTY1:    wmask = MASK_DUTY;
			IDX_DUTY2:    wmask = M_DUT2;
			IDX_DUTY3:    wmask = M_DUT2;
			IDX_AUX:      wmask = M_AUX;
			default:      wmask = RST_ZERO;
		endcase
	end

	// register writes and read data for the following cycle
	always_comb
	begin
		for (int i = 0; i < REG_COUNT; i++)
		begin
			nxt_regs[i] = regs_ff[i];
		end
		if (WR_I && ADDR_I < 4'(REG_COUNT))
		begin
			nxt_regs[ADDR_I[2:0]] = WDATA_I & wmask;
		end
		nxt_rdata = 16'h0000;
		if (RD_I && ADDR_I < 4'(REG_COUNT))
		begin
			nxt_rdata = regs_ff[ADDR_I[2:0]];
			if (ADDR_I == IDX_AUX)
			begin
				nxt_rdata[FAULT_STAT_BIT] = fault_active_ff;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			for (int i = 0; i < REG_COUNT; i++)
			begin
				regs_ff[i] <= RST_ZERO;
			end
			regs_ff[IDX_OVERRIDE[2:0]] <= R_OVR;
			rdata_ff <= 16'h0000;
		end
		else
		begin
			regs_ff  <= nxt_regs;
			rdata_ff <= nxt_rdata;
		end
	end

	assign RDATA_O = rdata_ff;

	// fault pin sync; level moves once stages two and three agree
	always_comb
	begin
		nxt_fault_lvl = fault_lvl_ff;
		if (fault_sync_ff[1] == fault_sync_ff[2])
		begin
			nxt_fault_lvl = fault_sync_ff[2];
		end
	end

	// fault override state; a new fault wins over any release
	assign fault_wr = WR_I && ADDR_I == IDX_FAULT;
	always_comb
	begin
		nxt_fault_active = fault_active_ff;
		if (fault_lvl_ff)
		begin
			nxt_fault_active = 1'b1;
		end
		else if (regs_ff[IDX_FAULT[2:0]][FAULT_MODE_BIT])
		begin
			if (PERIOD_BOUNDARY_I)
			begin
				nxt_fault_active = 1'b0;
			end
		end
		else if (fault_wr)
		begin
			nxt_fault_active = 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			fault_sync_ff   <= 3'h0;
			fault_lvl_ff    <= 1'b0;
			fault_active_ff <= 1'b0;
		end
		else
		begin
			fault_sync_ff   <= {fault_sync_ff[1:0], FAULT_A_I};
			fault_lvl_ff    <= nxt_fault_lvl;
			fault_active_ff <= nxt_fault_active;
		end
	end

	assign force_now = fault_lvl_ff | fault_active_ff;

	// working copy of the override register, taken at boundary or next cycle
	assign ovr_take = !regs_ff[IDX_AUX[2:0]][OVERRIDE_SYNC_ENABLE_BIT] || PERIOD_BOUNDARY_I;
	always_comb
	begin
		nxt_ovr_eff = ovr_eff_ff;
		if (ovr_take)
		begin
			nxt_ovr_eff = regs_ff[IDX_OVERRIDE[2:0]];
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			ovr_eff_ff <= R_OVR;
		end
		else
		begin
			ovr_eff_ff <= nxt_ovr_eff;
		end
	end

	// one generator with its dead-time counter per pair
	for (genvar g = 0; g < PAIRS; g++)
	begin : g_gen
		logic [15:0] duty;
		logic        raw;
		logic        gen_ff;
		logic [5:0]  dead_ff;
		logic [5:0]  nxt_dead;
		logic [2:0]  pre_ff;
		logic [2:0]  nxt_pre;
		logic [2:0]  pre_last_ff;
		logic [2:0]  nxt_pre_last;
		logic        use_b;
		logic        indep;
		logic [1:0]  ps_sel;
		logic [5:0]  cnt_sel;

		assign duty  = regs_ff[IDX_DUTY1[2:0] + 3'(g)];
		assign raw   = duty[15:1] > TB_COUNT_I;
		assign indep = regs_ff[IDX_AUX[2:0]][INDEP_LSB + g];
		// active edge uses the odd select, inactive edge the even one
		assign use_b = raw ? regs_ff[IDX_DT_SEL[2:0]][2*g+1]
		                   : regs_ff[IDX_DT_SEL[2:0]][2*g];
		assign ps_sel  = use_b ? regs_ff[IDX_DT_CTRL[2:0]][DTB_PS_LSB +: 2]
		                       : regs_ff[IDX_DT_CTRL[2:0]][DTA_PS_LSB +: 2];
		assign cnt_sel = use_b ? regs_ff[IDX_DT_CTRL[2:0]][DTB_CNT_LSB +: 6]
		                       : regs_ff[IDX_DT_CTRL[2:0]][DTA_CNT_LSB +: 6];

		// load dead time on a generator edge, then count prescaled ticks
		always_comb
		begin
			nxt_dead     = dead_ff;
			nxt_pre      = pre_ff;
			nxt_pre_last = pre_last_ff;
			if (raw != gen_ff && !indep)
			begin
				nxt_dead     = cnt_sel;
				nxt_pre      = 3'h0;
				nxt_pre_last = prescale_last(ps_sel);
			end
			else if (dead_ff != 6'h00)
			begin
				if (pre_ff == pre_last_ff)
				begin
					nxt_pre  = 3'h0;
					nxt_dead = dead_ff - 6'h01;
				end
				else
				begin
					nxt_pre = pre_ff + 3'h1;
				end
			end
		end

		always_ff @(posedge CLK_I or negedge RESETN_I)
		begin
			if (!RESETN_I)
			begin
				gen_ff      <= 1'b0;
				dead_ff     <= 6'h00;
				pre_ff      <= 3'h0;
				pre_last_ff <= 3'h0;
			end
			else
			begin
				gen_ff      <= raw;
				dead_ff     <= nxt_dead;
				pre_ff      <= nxt_pre;
				pre_last_ff <= nxt_pre_last;
			end
		end

		// complementary pair holds both sides off during dead time
		always_comb
		begin
			if (indep)
			begin
				gen_pins[g].high = gen_ff;
				gen_pins[g].low  = gen_ff;
			end
			else
			begin
				gen_pins[g].high = gen_ff && dead_ff == 6'h00;
				gen_pins[g].low  = !gen_ff && dead_ff == 6'h00;
			end
		end

		// pin choice: fault, then manual override, then generator
		always_comb
		begin
			nxt_pins[g].high = ovr_eff_ff[GEN_SEL_LSB + 2*g + 1] ? gen_pins[g].high
			                                                     : ovr_eff_ff[MANUAL_LSB + 2*g + 1];
			nxt_pins[g].low  = ovr_eff_ff[GEN_SEL_LSB + 2*g] ? gen_pins[g].low
			                                                 : ovr_eff_ff[MANUAL_LSB + 2*g];
			if (force_now && regs_ff[IDX_FAULT[2:0]][g])
			begin
				nxt_pins[g].high = regs_ff[IDX_FAULT[2:0]][FORCE_LSB + 2*g + 1];
				nxt_pins[g].low  = regs_ff[IDX_FAULT[2:0]][FORCE_LSB + 2*g];
			end
			if (SINGLE_PAIR && g != 0)
			begin
				nxt_pins[g] = '0;
			end
		end

		always_ff @(posedge CLK_I or negedge RESETN_I)
		begin
			if (!RESETN_I)
			begin
				pins_ff[g] <= '0;
			end
			else
			begin
				pins_ff[g] <= nxt_pins[g];
			end
		end

		assign HIGH_SIDE_OUTPUT_O[g] = pins_ff[g].high;
		assign LOW_SIDE_OUTPUT_O[g]  = pins_ff[g].low;

		// dead time from unit A, count 2, two cycles per count
		sequence s_dead_a_start;
			$rose(raw) && !indep && !use_b && cnt_sel == 6'h02 && ps_sel == 2'h1;
		endsequence
		a_dead_a_length: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
			s_dead_a_start |=> (dead_ff != 6'h00)[*4] ##1 dead_ff == 6'h00)
			else $error("unit A dead time length wrong");

		// dead time from unit B, count 1, eight cycles per count
		sequence s_dead_b_start;
			$fell(raw) && !indep && use_b && cnt_sel == 6'h01 && ps_sel == 2'h3;
		endsequence
		a_dead_b_length: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
			s_dead_b_start |=> (dead_ff != 6'h00)[*8] ##1 dead_ff == 6'h00)
			else $error("unit B dead time length wrong");

		a_dead_both_off: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
			(dead_ff != 6'h00 && !indep && !force_now && ovr_eff_ff[GEN_SEL_LSB + 2*g +: 2] == 2'h3)
			|=> !pins_ff[g].high && !pins_ff[g].low)
			else $error("pair not off during dead time");

		a_fault_force_pin: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
			(force_now && regs_ff[IDX_FAULT[2:0]][g] && !(SINGLE_PAIR && g != 0))
			|=> pins_ff[g].high == $past(regs_ff[IDX_FAULT[2:0]][FORCE_LSB + 2*g + 1]))
			else $error("fault force value not on high pin");

		a_manual_pin: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
			(!ovr_eff_ff[GEN_SEL_LSB + 2*g + 1] && !force_now && !(SINGLE_PAIR && g != 0))
			|=> pins_ff[g].high == $past(ovr_eff_ff[MANUAL_LSB + 2*g + 1]))
			else $error("manual level not on high pin");
	end

	a_cycle_release: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		(fault_active_ff && !fault_lvl_ff && PERIOD_BOUNDARY_I && regs_ff[IDX_FAULT[2:0]][FAULT_MODE_BIT])
		|=> !fault_active_ff)
		else $error("cycle mode fault not released at boundary");

	a_latch_hold: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		(fault_active_ff && !regs_ff[IDX_FAULT[2:0]][FAULT_MODE_BIT] && !fault_wr)
		|=> fault_active_ff)
		else $error("latched fault released without a write");

	a_sync_wait: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		(regs_ff[IDX_AUX[2:0]][OVERRIDE_SYNC_ENABLE_BIT] && !PERIOD_BOUNDARY_I) |=> $stable(ovr_eff_ff))
		else $error("override applied off the boundary");

	a_unmapped_zero: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		(RD_I && (ADDR_I >= 4'(REG_COUNT) || ADDR_I == IDX_DT_SEL)) |=> RDATA_O[15:6] == 10'h000)
		else $error("unimplemented bits read nonzero");

endmodule : motor_pwm_output_stage

`default_nettype wire

/* rtl/pwm_out_pkg.sv */
// Purpose: shared constants and types for the motor pwm output stage
// Assumes: one 50 MHz clock, 16-bit registers reached by word index
// Notes:   masks give the implemented bits of each register

`default_nettype none

package pwm_out_pkg;

	localparam int          CLK_HZ         = 50_000_000;
	localparam int          PAIRS          = 3;
	localparam int          ADDR_W         = 4;

	// register word indices
	localparam logic [3:0]  IDX_DT_CTRL    = 4'h0;
	localparam logic [3:0]  IDX_DT_SEL     = 4'h1;
	localparam logic [3:0]  IDX_FAULT      = 4'h2;
	localparam logic [3:0]  IDX_OVERRIDE   = 4'h3;
	localparam logic [3:0]  IDX_DUTY1      = 4'h4;
	localparam logic [3:0]  IDX_DUTY2      = 4'h5;
	localparam logic [3:0]  IDX_DUTY3      = 4'h6;
	localparam logic [3:0]  IDX_AUX        = 4'h7;
	localparam int          REG_COUNT      = 8;

	// field positions
	localparam int          DTB_PS_LSB     = 14;
	localparam int          DTB_CNT_LSB    = 8;
	localparam int          DTA_PS_LSB     = 6;
	localparam int          DTA_CNT_LSB    = 0;
	localparam int          FORCE_LSB      = 8;
	localparam int          FAULT_MODE_BIT = 7;
	localparam int          GEN_SEL_LSB    = 8;
	localparam int          MANUAL_LSB     = 0;
	localparam int          INDEP_LSB      = 8;
	localparam int          OVERRIDE_SYNC_ENABLE_BIT      = 1;
	localparam int          FAULT_STAT_BIT = 15;

	// implemented bits, full instance and single-pair instance
	localparam logic [15:0] MASK_DT_CTRL   = 16'hffff;
	localparam logic [15:0] MASK_DT_SEL    = 16'h003f;
	localparam logic [15:0] MASK_DT_SEL_1  = 16'h0003;
	localparam logic [15:0] MASK_FAULT     = 16'h3f87;
	localparam logic [15:0] MASK_FAULT_1   = 16'h0381;
	localparam logic [15:0] MASK_OVR       = 16'h3f3f;
	localparam logic [15:0] MASK_OVR_1     = 16'h0303;
	localparam logic [15:0] MASK_DUTY      = 16'hffff;
	localparam logic [15:0] MASK_AUX       = 16'h0702;
	localparam logic [15:0] MASK_AUX_1     = 16'h0102;

	// reset values
	localparam logic [15:0] RST_ZERO       = 16'h0000;
	localparam logic [15:0] RST_OVR        = 16'h3f00;
	localparam logic [15:0] RST_OVR_1      = 16'h0300;

	// drive levels of one pin pair
	typedef struct packed {
		logic high;
		logic low;
	} pin_pair_s;

	// last count of a dead-time prescaler: 1, 2, 4 or 8 cycles per count
	function automatic logic [2:0] prescale_last(input logic [1:0] ps);
		logic [3:0] span;
		span = 4'h1 << ps;
		return 3'(span - 4'h1);
	endfunction : prescale_last

endpackage : pwm_out_pkg

`default_nettype wire

/* verification/pwm_far_side.sv */
// Purpose: far-side model: fault source and gate drivers of the power stage
// Assumes: fault level is requested by the bench
// Notes:   the fault pin settles a few ns off the clock edge, like a comparator
`timescale 1ns/1ps
`default_nettype none
module pwm_far_side (
	input  wire logic       fault_req_i,
	input  wire logic [2:0] high_i,
	input  wire logic [2:0] low_i,
	output logic            fault_o,
	output logic            overlap_o
);
	// fault pin lags the request, unrelated to the clock
	initial
	begin
		fault_o = 1'b0;
		forever
		begin
			@(fault_req_i);
			fault_o <= #3 fault_req_i;
		end
	end
	// a pair driven on both sides at once would short the bridge leg
	assign overlap_o = |(high_i & low_i);
endmodule : pwm_far_side
`default_nettype wire

/* verification/test_motor_pwm_output_stage.sv */
// Purpose: self-checking bench for the motor pwm output stage
// Assumes: time base driven here, fault pin by the far-side model
// Notes:   random values from a fixed seed, corner cases among them
`timescale 1ns/1ps
`default_nettype none
module test_motor_pwm_output_stage
	import pwm_out_pkg::*;
;
	logic              clk = 1'b0;
	logic              resetn = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [15:0]       wdata = '0;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic [15:0]       rdata;
	logic [14:0]       tb_count = '0;
	logic              boundary = 1'b0;
	logic              fault_req = 1'b0;
	logic              fault_pin;
	logic              overlap;
	logic [2:0]        high;
	logic [2:0]        low;
	logic [15:0]       rdata_one;
	logic [2:0]        high_one;
	logic [2:0]        low_one;
	logic [15:0]       v;
	logic [15:0]       r;
	logic [5:0]        f;
	int                num_errors = 0;
	int                cmp_count = 0;
	int                cycles = 0;
	int                overlaps = 0;
	int                n;
	int                ca;
	int                cb;

	// 50 MHz clock
	always #10 clk = ~clk;

	motor_pwm_output_stage motor_pwm_output_stage_i (
		.CLK_I(clk), .RESETN_I(resetn), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TB_COUNT_I(tb_count),
		.PERIOD_BOUNDARY_I(boundary), .FAULT_A_I(fault_pin),
		.HIGH_SIDE_OUTPUT_O(high), .LOW_SIDE_OUTPUT_O(low)
	);
	pwm_far_side pwm_far_side_i (
		.fault_req_i(fault_req), .high_i(high), .low_i(low),
		.fault_o(fault_pin), .overlap_o(overlap)
	);
	// single-pair variant on the same bus, time base and fault pin
	if (1'b1)
	begin : g_single
		motor_pwm_output_stage #(
			.SINGLE_PAIR(1'b1)
		) motor_pwm_output_stage_i (
			.CLK_I(clk), .RESETN_I(resetn), .ADDR_I(addr), .WDATA_I(wdata),
			.WR_I(wr), .RD_I(rd), .RDATA_O(rdata_one), .TB_COUNT_I(tb_count),
			.PERIOD_BOUNDARY_I(boundary), .FAULT_A_I(fault_pin),
			.HIGH_SIDE_OUTPUT_O(high_one), .LOW_SIDE_OUTPUT_O(low_one)
		);
	end

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	// cut a hang short
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	task automatic settle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : settle

	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word

	task automatic chk_pins(input string what, input logic [5:0] exp);
		chk_word(what, {10'h000, exp}, {10'h000, high, low});
	endtask : chk_pins

	// change fault level and wait past the input synchroniser
	task automatic fault_set(input logic lvl);
		@(posedge clk);
		fault_req <= lvl;
		settle(8);
	endtask : fault_set

	// new duty on pair 1, count cycles with both sides off until one side rises
	task automatic gap(input logic [15:0] duty, input logic hi, output int cnt);
		wr_reg(IDX_DUTY1, duty);
		cnt = 0;
		for (int i = 0; i < 400; i++)
		begin
			@(posedge clk);
			#1;
			overlaps += int'(overlap);
			if ((hi ? high[0] : low[0]) === 1'b1)
				break;
			cnt += int'(!high[0] && !low[0]);
		end
	endtask : gap

	// register bit order H3 L3 H2 L2 H1 L1 to {high, low}
	function automatic logic [5:0] pins_of(input logic [5:0] b);
		return {b[5], b[3], b[1], b[4], b[2], b[0]};
	endfunction : pins_of

	// enabled pairs forced, others at idle complementary levels
	function automatic logic [5:0] forced(input logic [5:0] fv, input logic [2:0] en);
		return ({en, en} & pins_of(fv)) | (~{en, en} & 6'b000111);
	endfunction : forced

	// implemented bits per register, full or single-pair variant
	function automatic logic [15:0] mask_of(input int i, input bit one);
		case (i)
			0: return MASK_DT_CTRL;
			1: return one ? MASK_DT_SEL_1 : MASK_DT_SEL;
			2: return one ? MASK_FAULT_1 : MASK_FAULT;
			3: return one ? MASK_OVR_1 : MASK_OVR;
			4: return MASK_DUTY;
			5, 6: return one ? 16'h0000 : MASK_DUTY;
			7: return one ? MASK_AUX_1 : MASK_AUX;
			default: return 16'h0000;
		endcase
	endfunction : mask_of

	// main sequence
	initial
	begin
		void'($urandom(32'hfae1));
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			rd_reg(i[3:0], v);
			chk_word("reset value", (i == 3) ? RST_OVR : RST_ZERO, v);
		end
		$display("test reset values done");
		repeat (4)
		begin
			f = 6'($urandom);
			wr_reg(IDX_OVERRIDE, {10'h000, f});
			settle(3);
			chk_pins("manual pins", pins_of(f));
			chk_word("single pair pins", {10'h000, pins_of(f) & 6'b001001}, {10'h000, high_one, low_one});
		end
		wr_reg(IDX_OVERRIDE, RST_OVR);
		settle(3);
		chk_pins("generator pins", 6'b000111);
		$display("test manual override done");
		for (int e = 1; e < 8; e += 6)
		begin
			f = 6'($urandom);
			wr_reg(IDX_FAULT, {2'b00, f, 5'h00, e[2:0]});
			fault_set(1'b1);
			chk_pins("fault forced", forced(f, e[2:0]));
			fault_set(1'b0);
			chk_pins("fault latched", forced(f, e[2:0]));
			wr_reg(IDX_FAULT, {2'b00, f, 5'h00, e[2:0]});
			settle(4);
			chk_pins("fault cleared", 6'b000111);
		end
		f = 6'($urandom);
		wr_reg(IDX_FAULT, {2'b00, f, 5'h10, 3'h7});
		fault_set(1'b1);
		chk_pins("cycle forced", forced(f, 3'h7));
		fault_set(1'b0);
		chk_pins("cycle held", forced(f, 3'h7));
		@(posedge clk);
		boundary <= 1'b1;
		@(posedge clk);
		boundary <= 1'b0;
		settle(3);
		chk_pins("cycle released", 6'b000111);
		wr_reg(IDX_FAULT, RST_ZERO);
		$display("test fault done");
		// passes 10 and 11 fix unit A at count 2 and unit B at count 1 as corner cases
		for (int k = 0; k < 12; k++)
		begin
			ca = (k >= 10) ? 2 : 1 + $urandom % 15;
			cb = (k >= 10) ? 1 : 1 + $urandom % 15;
			wr_reg(IDX_DT_CTRL, {k[1:0], 6'(cb), ~k[1:0], 6'(ca)});
			wr_reg(IDX_DT_SEL, {14'h0000, k[2], ~k[2]});
			settle(2);
			gap(16'h0002, 1'b1, n);
			chk_word("rise dead time", 16'(k[2] ? cb << k[1:0] : ca << ~k[1:0]), 16'(n));
			gap(16'h0000, 1'b0, n);
			chk_word("fall dead time", 16'(k[2] ? ca << ~k[1:0] : cb << k[1:0]), 16'(n));
		end
		chk_word("overlap cycles", 16'h0000, 16'(overlaps));
		$display("test dead time done");
		wr_reg(IDX_DT_CTRL, RST_ZERO);
		wr_reg(IDX_AUX, 16'h0100);
		wr_reg(IDX_DUTY1, 16'h0002);
		settle(4);
		chk_pins("independent pins", 6'b001111);
		// time base at or past half the duty value ends the pulse on both independent outputs
		@(posedge clk);
		tb_count <= 15'($urandom) | 15'h0001;
		settle(3);
		chk_pins("time base past duty", 6'b000110);
		@(posedge clk);
		tb_count <= 15'h0000;
		wr_reg(IDX_AUX, 16'h0002);
		wr_reg(IDX_DUTY1, RST_ZERO);
		wr_reg(IDX_OVERRIDE, 16'h002a);
		settle(4);
		chk_pins("sync held pins", 6'b000111);
		@(posedge clk);
		boundary <= 1'b1;
		@(posedge clk);
		boundary <= 1'b0;
		settle(3);
		chk_pins("sync applied pins", pins_of(6'h2a));
		$display("test pair mode and sync done");
		for (int i = 0; i < 40; i++)
		begin
			n = $urandom % 10;
			v = 16'($urandom);
			wr_reg(n[3:0], v);
			rd_reg(n[3:0], r);
			chk_word("single pair readback", v & mask_of(n, 1'b1), rdata_one);
			chk_word("register readback", v & mask_of(n, 1'b0), r);
		end
		$display("test register access done");
		end_of_test();
	end
endmodule : test_motor_pwm_output_stage
`default_nettype wire
